// ---- rtl/cpts_top.sv ----
// cpu priority level, nesting control and processor trap status
// assumes core event inputs are one-cycle pulses on aclk; the oscillator
// failure level comes from outside the clock domain
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module cpts_top import cpts_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              acc_a_ovf,
  input  wire logic              acc_b_ovf,
  input  wire logic              acc_a_cat,
  input  wire logic              acc_b_cat,
  input  wire logic              shift_err,
  input  wire logic              div_zero,
  input  wire logic              math_other,
  input  wire logic              dma_err,
  input  wire logic              addr_err,
  input  wire logic              stack_err,
  input  wire logic              osc_fail_pin,
  input  wire logic              level_load,
  input  wire logic [LVL_W-1:0]  level_value,
  input  wire logic              exc_busy,
  input  wire logic              pend_valid,
  input  wire logic [PRIO_W-1:0] pend_prio,
  output logic [LVL_W-1:0]       cpu_level,
  output logic                   var_latency,
  output logic                   nest_disable,
  output logic                   irq_accept,
  output logic                   math_trap,
  output logic                   addr_trap,
  output logic                   stack_trap,
  output logic                   dma_trap,
  output logic                   osc_trap,
  output logic                   irq
);

  typedef struct packed {
    logic [PRIO_W-1:0] prio;
    logic              msb;
    logic              var_lat;
    logic [REG_W-1:0]  tc;
    logic [REG_W-1:0]  sts;
    logic [REG_W-1:0]  msk;
    logic [4:0]        trap;
    logic              osc_prev;
    logic              irq;
  } cpts_top_state_type;

  cpts_top_state_type st_q;
  cpts_top_state_type st_d;

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [REG_W-1:0]  wr_data;
  logic [1:0]        wr_strb;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [REG_W-1:0]  rd_data;
  logic              osc_s;
  logic [REG_W-1:0]  ev;
  logic              wr_csw;
  logic              wr_ccw;
  logic              wr_tc;
  logic              wr_msk;
  logic              rd_sts;

  cpts_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data)
  );

  cpts_sync u_osc_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in (osc_fail_pin),
    .sync_out (osc_s)
  );

  assign wr_csw = wr_en && (wr_addr == OFF_CSW);
  assign wr_ccw = wr_en && (wr_addr == OFF_CCW);
  assign wr_tc  = wr_en && (wr_addr == OFF_TC1);
  assign wr_msk = wr_en && (wr_addr == OFF_MSK);
  assign rd_sts = rd_en && (rd_addr == OFF_STS);

  // trap events, already gated by their enables
  always_comb
  begin
    ev = '0;
    ev[TC_OVA_F]  = acc_a_ovf & st_q.tc[TC_OVA_EN];
    ev[TC_OVB_F]  = acc_b_ovf & st_q.tc[TC_OVB_EN];
    ev[TC_COVA_F] = acc_a_cat & st_q.tc[TC_COV_EN];
    ev[TC_COVB_F] = acc_b_cat & st_q.tc[TC_COV_EN];
    ev[TC_SFT_F]  = shift_err;
    ev[TC_DIV_F]  = div_zero;
    ev[TC_DMA_F]  = dma_err;
    ev[TC_MATH_F] = (|(ev & TC_MATH_SRC)) | math_other;
    ev[TC_ADDR_F] = addr_err;
    ev[TC_STK_F]  = stack_err;
    ev[TC_OSC_F]  = osc_s & ~st_q.osc_prev;
  end

  always_comb
  begin
    logic lane;
    lane = 1'b0;
    st_d = st_q;
    if (ce)
    begin
      st_d.osc_prev = osc_s;
      st_d.trap = {ev[TC_OSC_F], ev[TC_DMA_F], ev[TC_STK_F], ev[TC_ADDR_F], ev[TC_MATH_F]};
      if (wr_csw && wr_strb[0] && !st_q.tc[TC_NEST])
        st_d.prio = wr_data[CSW_PRIO_LSB +: PRIO_W];
      if (wr_ccw && wr_strb[1])
        st_d.var_lat = wr_data[CCW_VAR_BIT];
      // software can only drop the msb so traps cannot be masked from code
      if (wr_ccw && wr_strb[0] && !wr_data[CCW_MSB_BIT])
        st_d.msb = 1'b0;
      if (level_load)
        {st_d.msb, st_d.prio} = level_value;
      for (int i = 0; i < REG_W; i++)
      begin
        lane = wr_strb[i / 8];
        if (TC_CTRL_MASK[i] && wr_tc && lane)
          st_d.tc[i] = wr_data[i];
        // a trap in the same cycle as a clearing write keeps its flag
        if (TC_FLAG_MASK[i])
          st_d.tc[i] = ev[i] | (st_q.tc[i] & ~(wr_tc & lane & ~wr_data[i]));
        else if (!TC_CTRL_MASK[i])
          st_d.tc[i] = 1'b0;
        st_d.sts[i] = ev[i] | (st_q.sts[i] & ~rd_sts);
        if (wr_msk && lane)
          st_d.msk[i] = wr_data[i] & TC_FLAG_MASK[i];
      end
      st_d.irq = |(st_d.sts & st_d.msk);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  always_comb
  begin
    rd_data = '0;
    case (rd_addr)
      OFF_CSW: rd_data[CSW_PRIO_LSB +: PRIO_W] = st_q.prio;
      OFF_CCW:
      begin
        rd_data[CCW_VAR_BIT] = st_q.var_lat;
        rd_data[CCW_MSB_BIT] = st_q.msb;
      end
      OFF_TC1: rd_data = st_q.tc;
      OFF_STS: rd_data = st_q.sts;
      OFF_MSK: rd_data = st_q.msk;
      default: rd_data = '0;
    endcase
  end

  assign cpu_level    = {st_q.msb, st_q.prio};
  assign var_latency  = st_q.var_lat;
  assign nest_disable = st_q.tc[TC_NEST];
  // user sources top out at 7, so level 7 or above blocks them all
  assign irq_accept = pend_valid && ({1'b0, pend_prio} > cpu_level) &&
                      !(st_q.tc[TC_NEST] && exc_busy);
  assign math_trap  = st_q.trap[0];
  assign addr_trap  = st_q.trap[1];
  assign stack_trap = st_q.trap[2];
  assign dma_trap   = st_q.trap[3];
  assign osc_trap   = st_q.trap[4];
  assign irq        = st_q.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_reset_level;
    !$past(aresetn) |-> (cpu_level == LEVEL_RST) && !nest_disable && !var_latency;
  endproperty
  a_reset_level: assert property (p_reset_level)
    else $error("level not zero after reset");

  property p_prio_locked;
    ce && wr_csw && wr_strb[0] && st_q.tc[TC_NEST] && !level_load
      |=> cpu_level[PRIO_W-1:0] == $past(cpu_level[PRIO_W-1:0]);
  endproperty
  a_prio_locked: assert property (p_prio_locked)
    else $error("priority field written while nesting disabled");

  property p_prio_write;
    ce && wr_csw && wr_strb[0] && !st_q.tc[TC_NEST] && !level_load
      |=> cpu_level[PRIO_W-1:0] == $past(wr_data[CSW_PRIO_LSB +: PRIO_W]);
  endproperty
  a_prio_write: assert property (p_prio_write)
    else $error("priority field write lost");

  property p_msb_no_set;
    ce && !level_load && !cpu_level[LVL_W-1] |=> !cpu_level[LVL_W-1];
  endproperty
  a_msb_no_set: assert property (p_msb_no_set)
    else $error("msb rose without a hardware load");

  property p_var_write;
    ce && wr_ccw && wr_strb[1] |=> var_latency == $past(wr_data[CCW_VAR_BIT]);
  endproperty
  a_var_write: assert property (p_var_write)
    else $error("latency select not written");

  property p_ova_gate;
    ce && acc_a_ovf && !st_q.tc[TC_OVA_EN] && !st_q.tc[TC_OVA_F] |=> !st_q.tc[TC_OVA_F];
  endproperty
  a_ova_gate: assert property (p_ova_gate)
    else $error("disabled overflow trap set its flag");

  property p_cat_trap;
    ce && acc_b_cat && st_q.tc[TC_COV_EN]
      |=> st_q.tc[TC_COVB_F] && st_q.tc[TC_MATH_F] && math_trap;
  endproperty
  a_cat_trap: assert property (p_cat_trap)
    else $error("catastrophic trap not flagged");

  property p_div_trap;
    ce && div_zero |=> (st_q.tc[TC_DIV_F] && st_q.tc[TC_MATH_F] && math_trap) ##1
      (!math_trap || $past(ev[TC_MATH_F]) || !$past(ce));
  endproperty
  a_div_trap: assert property (p_div_trap)
    else $error("divide by zero trap not flagged");

  property p_addr_trap;
    ce && addr_err |=> st_q.tc[TC_ADDR_F] && addr_trap && st_q.sts[TC_ADDR_F];
  endproperty
  a_addr_trap: assert property (p_addr_trap)
    else $error("address trap not flagged");

  property p_level_load;
    ce && level_load |=> cpu_level == $past(level_value);
  endproperty
  a_level_load: assert property (p_level_load)
    else $error("hardware level load lost");

  property p_msb_clear;
    ce && wr_ccw && wr_strb[0] && !wr_data[CCW_MSB_BIT] && !level_load
      |=> !cpu_level[LVL_W-1];
  endproperty
  a_msb_clear: assert property (p_msb_clear)
    else $error("msb not cleared by software");

  property p_nest_write;
    ce && wr_tc && wr_strb[1] |=> nest_disable == $past(wr_data[TC_NEST]);
  endproperty
  a_nest_write: assert property (p_nest_write)
    else $error("nesting disable not written");

  property p_cat_gate;
    ce && acc_a_cat && !st_q.tc[TC_COV_EN] && !st_q.tc[TC_COVA_F] |=> !st_q.tc[TC_COVA_F];
  endproperty
  a_cat_gate: assert property (p_cat_gate)
    else $error("disabled catastrophic trap set its flag");

  property p_shift_only;
    ce && !shift_err && !st_q.tc[TC_SFT_F] |=> !st_q.tc[TC_SFT_F];
  endproperty
  a_shift_only: assert property (p_shift_only)
    else $error("shift flag set without a shift error");

  property p_math_any;
    ce && (shift_err || div_zero || math_other) |=> st_q.tc[TC_MATH_F] && math_trap;
  endproperty
  a_math_any: assert property (p_math_any)
    else $error("math error flag missing");

  property p_dma_trap;
    ce && dma_err |=> st_q.tc[TC_DMA_F] && dma_trap;
  endproperty
  a_dma_trap: assert property (p_dma_trap)
    else $error("dma trap not flagged");

  property p_osc_edge;
    ce && osc_s && !st_q.osc_prev |=> st_q.tc[TC_OSC_F] && osc_trap;
  endproperty
  a_osc_edge: assert property (p_osc_edge)
    else $error("oscillator failure not flagged");

  property p_flag_hold;
    ce && st_q.tc[TC_STK_F] && !wr_tc |=> st_q.tc[TC_STK_F];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("stack flag dropped without a write");

  property p_accept;
    &cpu_level[PRIO_W-1:0] || cpu_level[LVL_W-1] || ({1'b0, pend_prio} == cpu_level) ||
      (nest_disable && exc_busy) |-> !irq_accept;
  endproperty
  a_accept: assert property (p_accept)
    else $error("interrupt accepted at or below cpu level");

  c_prio_write: cover property (ce && wr_csw && !st_q.tc[TC_NEST]);
  c_trap_irq:   cover property (ce && addr_err ##2 irq);
  c_nest_block: cover property (pend_valid && exc_busy && nest_disable);
  c_osc_trap:   cover property (ce && osc_trap);

endmodule

// ---- rtl/cpts_pkg.sv ----
// constants shared by the cpu priority and trap status block
// assumes one 40 MHz clock, a synchronous active-low reset and an axi4-lite master
// Function
// - three-bit cpu priority field in status bits 7:5; level 7 blocks user interrupts
// - full cpu level is priority_level_msb above the three-bit field, levels 8 to 15
// - while nesting_disable is set, software writes to the priority field are ignored
// - priority_level_msb reads one above level 7, resets zero, software may only clear
// - variable_latency_select at control bit 15, resets zero, one selects variable
// - nesting_disable at trap control bit 15, resets zero, one stops nesting
// - accumulator a and b overflow traps set flags at bits 14 and 13
// - catastrophic overflow of a and b sets flags at bits 12 and 11
// - overflow traps for a and b only while their enables at bits 10, 9 are set
// - catastrophic overflow traps only while catastrophic_trap_en at bit 8 is set
// - shift_error_flag at bit 7 set only for invalid accumulator shift math traps
// - divide_zero_flag at bit 6 set when divide by zero causes the math trap
// - dma_trap_flag at bit 5 set on a trap from the dma controller
// - math_error_flag at bit 4 set on any math error trap
// - address, stack and oscillator traps set bits 3, 2, 1; bit 0 reads zero
// - after reset the cpu level is 0, accepting any enabled user interrupt
// - during exception processing accept only strictly higher priority sources
package cpts_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int PRIO_W = 3;
  localparam int LVL_W  = 4;

  localparam logic [ADDR_W-1:0] OFF_CSW = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CCW = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TC1 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MSK = 8'h10;

  localparam int CSW_PRIO_LSB = 5;
  localparam int CCW_VAR_BIT  = 15;
  localparam int CCW_MSB_BIT  = 3;

  localparam int TC_NEST   = 15;
  localparam int TC_OVA_F  = 14;
  localparam int TC_OVB_F  = 13;
  localparam int TC_COVA_F = 12;
  localparam int TC_COVB_F = 11;
  localparam int TC_OVA_EN = 10;
  localparam int TC_OVB_EN = 9;
  localparam int TC_COV_EN = 8;
  localparam int TC_SFT_F  = 7;
  localparam int TC_DIV_F  = 6;
  localparam int TC_DMA_F  = 5;
  localparam int TC_MATH_F = 4;
  localparam int TC_ADDR_F = 3;
  localparam int TC_STK_F  = 2;
  localparam int TC_OSC_F  = 1;

  localparam logic [REG_W-1:0] TC_FLAG_MASK = 16'h78fe;
  localparam logic [REG_W-1:0] TC_CTRL_MASK = 16'h8700;
  localparam logic [REG_W-1:0] TC_MATH_SRC  = 16'h78c0;

  localparam logic [LVL_W-1:0] LEVEL_RST = 4'h0;
  localparam logic [1:0]       RESP_OKAY = 2'b00;
  localparam logic [1:0]       RESP_SLVERR = 2'b10;

  function automatic logic cpts_addr_ok(input logic [ADDR_W-1:0] a);
    return (a == OFF_CSW) || (a == OFF_CCW) || (a == OFF_TC1) ||
           (a == OFF_STS) || (a == OFF_MSK);
  endfunction

endpackage

// ---- rtl/cpts_sync.sv ----
// two-flop synchroniser for one level from outside the clock domain
// assumes the level stays stable for at least two clock cycles
`timescale 1ns/1ps
module cpts_sync import cpts_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic meta;
    logic held;
  } cpts_sync_state_type;

  cpts_sync_state_type st_q;
  cpts_sync_state_type st_d;

  always_comb
  begin
    st_d = st_q;
    if (ce)
    begin
      st_d.meta = async_in;
      st_d.held = st_q.meta;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_out = st_q.held;

endmodule

// ---- rtl/cpts_axil.sv ----
// axi4-lite slave front end: one write and one read in flight at most
// assumes a compliant master; register file answers reads combinationally
`timescale 1ns/1ps
module cpts_axil import cpts_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [REG_W-1:0]       wr_data,
  output logic [1:0]             wr_strb,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [REG_W-1:0]  rd_data
);

  typedef struct packed {
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] awaddr;
    logic [REG_W-1:0]  wdata;
    logic [1:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [REG_W-1:0]  rdata;
    logic [1:0]        rresp;
  } cpts_axil_state_type;

  cpts_axil_state_type st_q;
  cpts_axil_state_type st_d;

  // registers are 16 bits wide; upper data lanes are dropped on write
  assign s_axi_awready = ~st_q.aw_full & ~st_q.bvalid;
  assign s_axi_wready  = ~st_q.w_full & ~st_q.bvalid;
  assign s_axi_arready = ~st_q.rvalid;
  assign wr_en   = ce & st_q.aw_full & st_q.w_full & ~st_q.bvalid;
  assign wr_addr = st_q.awaddr;
  assign wr_data = st_q.wdata;
  assign wr_strb = st_q.wstrb;
  assign rd_en   = ce & s_axi_arvalid & ~st_q.rvalid;
  assign rd_addr = s_axi_araddr;

  always_comb
  begin
    st_d = st_q;
    if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        st_d.aw_full = 1'b1;
        st_d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        st_d.w_full = 1'b1;
        st_d.wdata  = s_axi_wdata[REG_W-1:0];
        st_d.wstrb  = s_axi_wstrb[1:0];
      end
      if (wr_en)
      begin
        st_d.aw_full = 1'b0;
        st_d.w_full  = 1'b0;
        st_d.bvalid  = 1'b1;
        st_d.bresp   = cpts_addr_ok(st_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (st_q.bvalid && s_axi_bready)
        st_d.bvalid = 1'b0;
      if (rd_en)
      begin
        st_d.rvalid = 1'b1;
        st_d.rdata  = rd_data;
        st_d.rresp  = cpts_addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (st_q.rvalid && s_axi_rready)
        st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp  = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rresp  = st_q.rresp;
  assign s_axi_rdata  = {{(DATA_W-REG_W){1'b0}}, st_q.rdata};

endmodule

// ---- verification/cpts_core_model.sv ----
// core-side model: trap event pulses, level loads and the pending source
// assumes the bench calls its tasks just after a rising edge of aclk
`timescale 1ns/1ps
module cpts_core_model import cpts_pkg::*;
(
  input  wire logic         aclk,
  output logic [9:0]        ev,
  output logic              osc_fail_pin,
  output logic              level_load,
  output logic [LVL_W-1:0]  level_value,
  output logic              exc_busy,
  output logic              pend_valid,
  output logic [PRIO_W-1:0] pend_prio
);
  initial
  begin
    ev = '0;
    osc_fail_pin = 1'b0;
    level_load = 1'b0;
    level_value = 4'h0;
    exc_busy = 1'b0;
    pend_valid = 1'b0;
    pend_prio = 3'h1;
  end

  // index 10 is the oscillator level; it is held long enough to cross the synchroniser
  task automatic pulse(input int i);
    if (i == 10)
    begin
      osc_fail_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      osc_fail_pin <= 1'b0;
    end
    else
    begin
      ev <= 10'h001 << i;
      @(posedge aclk);
      ev <= '0;
    end
    @(posedge aclk);
  endtask

  task automatic load(input logic [LVL_W-1:0] v);
    level_load <= 1'b1;
    level_value <= v;
    @(posedge aclk);
    level_load <= 1'b0;
    // the old value is not left standing once the load is taken
    level_value <= ~v;
    @(posedge aclk);
  endtask

  task automatic pend(input logic b, input logic [PRIO_W-1:0] p);
    exc_busy <= b;
    pend_valid <= 1'b1;
    pend_prio <= p;
    @(posedge aclk);
  endtask
endmodule

// ---- verification/cpts_top_tb_top.sv ----
// self-checking bench for the priority and trap status block
// assumes the core model drives the core inputs; the bench is the bus master
`timescale 1ns/1ps
module cpts_top_tb_top import cpts_pkg::*;
;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, irq, irq_accept;
  logic              var_latency, nest_disable, osc, lload, busy, pvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic [LVL_W-1:0]  cpu_level, lval;
  logic [PRIO_W-1:0] pprio;
  logic [9:0]        ev;
  logic [4:0]        traps, tseen, texp;
  logic [REG_W-1:0]  m;
  logic [33:0]       e;
  logic [33:0]       q[$];
  int                fails, compares, cyc, seed, tcnt;
  localparam logic [15:0] FL [11] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810,
    16'h0090, 16'h0050, 16'h0010, 16'h0020, 16'h0008, 16'h0004, 16'h0002};

  cpts_core_model i_core (.aclk(aclk), .ev(ev), .osc_fail_pin(osc), .level_load(lload),
    .level_value(lval), .exc_busy(busy), .pend_valid(pvalid), .pend_prio(pprio));

  cpts_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .acc_a_ovf(ev[0]), .acc_b_ovf(ev[1]), .acc_a_cat(ev[2]), .acc_b_cat(ev[3]),
    .shift_err(ev[4]), .div_zero(ev[5]), .math_other(ev[6]), .dma_err(ev[7]),
    .addr_err(ev[8]), .stack_err(ev[9]), .osc_fail_pin(osc), .level_load(lload),
    .level_value(lval), .exc_busy(busy), .pend_valid(pvalid), .pend_prio(pprio),
    .cpu_level(cpu_level), .var_latency(var_latency), .nest_disable(nest_disable),
    .irq_accept(irq_accept), .math_trap(traps[0]), .addr_trap(traps[1]),
    .stack_trap(traps[2]), .dma_trap(traps[3]), .osc_trap(traps[4]), .irq(irq));

  always #12.5 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // upper half of the write word is junk on purpose: it must be ignored
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
    q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= {16'h5a5a, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    // bready stays up: dropping it here would clash with the next call raising it
    while (!bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
    q.push_back({r, 16'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
  endtask

  // response watcher: each completed transfer retires the oldest expectation
  always @(posedge aclk)
    if ((bvalid && bready) || (rvalid && rready))
    begin
      e = q.pop_front();
      chk({30'h0, bvalid ? bresp : rresp}, {30'h0, e[33:32]});
      if (rvalid) chk(rdata, e[31:0]);
    end

  // trap outputs pulse for one cycle only, so gather them for later checks
  always @(posedge aclk)
  begin
    tseen <= aresetn ? (tseen | traps) : 5'h00;
    tcnt <= tcnt + $countones(traps);
  end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      $display("BAD %0t run did not finish", $time);
      final_report();
    end
  end

  initial
  begin
    seed = 32'h2001;
    texp = '0;
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 16'h0, RESP_OKAY);
    chk(32'(cpu_level), 32'h0);
    rd(8'h14, 16'h0, RESP_SLVERR);
    wr(8'h14, 16'hffff, RESP_SLVERR);
    $display("test reset and map done");
    wr(OFF_CSW, 16'hffff, RESP_OKAY);
    rd(OFF_CSW, 16'h00e0, RESP_OKAY);
    i_core.pend(1'b0, 3'h7);
    chk(32'(irq_accept), 32'h0);
    i_core.load(4'hc);
    rd(OFF_CSW, 16'h0080, RESP_OKAY);
    rd(OFF_CCW, 16'h0008, RESP_OKAY);
    chk(32'(cpu_level), 32'hc);
    wr(OFF_CCW, 16'h8000, RESP_OKAY);
    rd(OFF_CCW, 16'h8000, RESP_OKAY);
    chk(32'({var_latency, cpu_level}), 32'h14);
    wr(OFF_CCW, 16'h0008, RESP_OKAY);
    rd(OFF_CCW, 16'h0000, RESP_OKAY);
    $display("test priority level done");
    i_core.pend(1'b1, 3'h4);
    chk(32'(irq_accept), 32'h0);
    i_core.pend(1'b1, 3'h5);
    chk(32'(irq_accept), 32'h1);
    wr(OFF_TC1, 16'h8000, RESP_OKAY);
    i_core.pend(1'b1, 3'h5);
    chk(32'({nest_disable, irq_accept}), 32'h2);
    wr(OFF_CSW, 16'h0040, RESP_OKAY);
    rd(OFF_CSW, 16'h0080, RESP_OKAY);
    $display("test nesting done");
    wr(OFF_MSK, TC_FLAG_MASK, RESP_OKAY);
    wr(OFF_TC1, 16'h0700, RESP_OKAY);
    for (int i = 0; i < 11; i++)
    begin
      i_core.pulse(i);
      chk(32'(irq), 32'h1);
      rd(OFF_TC1, 16'h0700 | FL[i], RESP_OKAY);
      texp = texp | {FL[i][TC_OSC_F], FL[i][TC_DMA_F], FL[i][TC_STK_F], FL[i][TC_ADDR_F],
                     FL[i][TC_MATH_F]};
      chk(32'(tseen), 32'(texp));
      chk(tcnt, i + 1);
      wr(OFF_TC1, 16'h7ffe, RESP_OKAY);
      rd(OFF_TC1, 16'h0700 | FL[i], RESP_OKAY);
      wr(OFF_TC1, 16'h0700, RESP_OKAY);
      rd(OFF_TC1, 16'h0700, RESP_OKAY);
      m = 16'($random(seed)) & TC_FLAG_MASK;
      wr(OFF_MSK, m, RESP_OKAY);
      chk(32'(irq), 32'(|(FL[i] & m)));
      rd(OFF_STS, FL[i], RESP_OKAY);
      chk(32'(irq), 32'h0);
      wr(OFF_MSK, TC_FLAG_MASK, RESP_OKAY);
    end
    $display("test trap flags done");
    // each overflow kind fired with only the other kind's enables set
    for (int i = 0; i < 4; i++)
    begin
      m = (i < 2) ? 16'h0100 : 16'h0600;
      wr(OFF_TC1, m, RESP_OKAY);
      i_core.pulse(i);
      rd(OFF_TC1, m, RESP_OKAY);
      chk(32'(irq), 32'h0);
    end
    chk(tcnt, 32'hb);
    $display("test trap enables done");
    final_report();
  end
endmodule
